// ---- design/scm_cmd_select.sv ----
// command translator: maps a processor dram cycle to one sdram command per the selected mode
`timescale 1ns/1ps

module scm_cmd_select
	import scm_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// mode
	input  wire logic [2:0]        mode_in,
	// normal-path command
	input  wire logic [2:0]        normal_cmd_in,
	input  wire logic [ADDR_W-1:0] normal_addr_in,
	// host-derived address
	input  wire logic [ADDR_W-1:0] host_addr_in,
	// translated command
	output logic      [2:0]        cmd_out,
	output logic      [ADDR_W-1:0] addr_out,
	output logic                   special_out
);

	// ----------------------------------------
	// translation
	// ----------------------------------------
	always_comb begin
		cmd_out     = normal_cmd_in;
		addr_out    = normal_addr_in;
		special_out = 1'b1;
		case (mode_in)
			SCM_IDLE_COMMAND_MODE: begin
				cmd_out  = SCM_CMD_NOP;
				addr_out = host_addr_in;
			end
			SCM_PRECHARGE_ALL: begin
				cmd_out  = SCM_CMD_PRECHARGE;
				addr_out = host_addr_in;
				addr_out[SCM_ALL_BANKS_BIT] = 1'b1;
			end
			SCM_MODE_PROGRAM: begin
				cmd_out  = SCM_CMD_LOAD_MODE;
				addr_out = host_addr_in;
			end
			SCM_REFRESH_CYCLE: begin
				cmd_out  = SCM_CMD_REFRESH;
				addr_out = host_addr_in;
			end
			default: begin
				// normal and reserved codes pass the ordinary access
				special_out = 1'b0;
			end
		endcase
	end

endmodule

// ---- design/scm_pkg.sv ----
// package: register map, field layout and command codes of the sdram command-mode block
package scm_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0]  SCM_CTRL_OFFSET     = 8'h54;
	localparam logic [15:0] SCM_CTRL_RESET      = 16'h0000;
	localparam logic [15:0] SCM_CTRL_WRITE_MASK = 16'h0030;
	localparam logic [15:0] SCM_CTRL_READ_MASK  = 16'h01f0;
	localparam logic [15:0] SCM_UNMAPPED_DATA   = 16'h0000;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SCM_MODE_LSB = 6;
	localparam int SCM_MODE_MSB = 8;
	localparam int SCM_CAS_BIT  = 4;
	localparam int SCM_RCO_BIT  = 5;

	// ----------------------------------------
	// command-mode codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SCM_NORMAL_MODE       = 3'h0,
		SCM_IDLE_COMMAND_MODE = 3'h1,
		SCM_PRECHARGE_ALL     = 3'h2,
		SCM_MODE_PROGRAM      = 3'h3,
		SCM_REFRESH_CYCLE     = 3'h4
	} scm_mode_type;

	// ----------------------------------------
	// sdram command encodings {ras_n, cas_n, we_n}
	// ----------------------------------------
	typedef enum logic [2:0] {
		SCM_CMD_ACTIVE    = 3'h3,
		SCM_CMD_READ      = 3'h5,
		SCM_CMD_WRITE     = 3'h4,
		SCM_CMD_PRECHARGE = 3'h2,
		SCM_CMD_REFRESH   = 3'h1,
		SCM_CMD_LOAD_MODE = 3'h0,
		SCM_CMD_NOP       = 3'h7
	} scm_cmd_type;

	// precharge-all is flagged by this address line
	localparam int         SCM_ALL_BANKS_BIT = 10;
	localparam logic [2:0] SCM_CMD_IDLE      = 3'h7;

endpackage

// ---- design/scm_sdram_command_mode.sv ----
// sdram command-mode selector: control register and command issue toward the memory interface
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

module scm_sdram_command_mode
	import scm_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	// register port
	input  wire logic [7:0]        reg_addr_in,
	input  wire logic [15:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [15:0]       reg_rdata_out,
	// processor dram cycle
	input  wire logic              cpu_dram_req_in,
	input  wire logic              cpu_dram_write_in,
	input  wire logic [ADDR_W-1:0] cpu_mem_addr_in,
	// memory interface
	output logic      [ADDR_W-1:0] memory_address_lines_out,
	output logic                   ras_n_out,
	output logic                   cas_n_out,
	output logic                   we_n_out,
	// status
	output logic      [2:0]        special_command_mode_field_out,
	output logic                   cas_latency_select_out,
	output logic                   special_cycle_out
);

	// ----------------------------------------
	// control register
	// ----------------------------------------
	logic [2:0]        mode_field;
	logic [15:0]       ctrl_low;
	logic [2:0]        sel_cmd;
	logic [ADDR_W-1:0] sel_addr;
	logic              sel_special;
	logic [2:0]        normal_cmd;

	function automatic logic ctrl_hit(input logic [7:0] a);
		ctrl_hit = (a == SCM_CTRL_OFFSET);
	endfunction

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mode_field <= SCM_CTRL_RESET[SCM_MODE_MSB:SCM_MODE_LSB];
		end else if (reg_wr_in && ctrl_hit(reg_addr_in)) begin
			mode_field <= reg_wdata_in[SCM_MODE_MSB:SCM_MODE_LSB];
		end
	end

	// cas latency and ras-to-cas override bits kept beside the mode field
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl_low <= SCM_CTRL_RESET & SCM_CTRL_WRITE_MASK;
		end else if (reg_wr_in && ctrl_hit(reg_addr_in)) begin
			ctrl_low <= reg_wdata_in & SCM_CTRL_WRITE_MASK;
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			reg_rdata_out <= SCM_UNMAPPED_DATA;
		end else if (reg_rd_in && ctrl_hit(reg_addr_in)) begin
			reg_rdata_out <= {7'h00, mode_field, 6'h00} | ctrl_low;
		end else begin
			reg_rdata_out <= SCM_UNMAPPED_DATA;
		end
	end

	assign special_command_mode_field_out = mode_field;
	// zero selects latency three; mode programming drives the host address unchanged, without this bit on address line 4
	assign cas_latency_select_out = ctrl_low[SCM_CAS_BIT];

	// ----------------------------------------
	// command selection
	// ----------------------------------------
	always_comb begin
		normal_cmd = cpu_dram_write_in ? SCM_CMD_WRITE : SCM_CMD_READ;
	end

	scm_cmd_select #(
		.ADDR_W(ADDR_W)
	) u_sel (
		.mode_in        (mode_field),
		.normal_cmd_in  (normal_cmd),
		.normal_addr_in (cpu_mem_addr_in),
		.host_addr_in   (cpu_mem_addr_in),
		.cmd_out        (sel_cmd),
		.addr_out       (sel_addr),
		.special_out    (sel_special)
	);

	// ----------------------------------------
	// memory interface drive
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			{ras_n_out, cas_n_out, we_n_out} <= SCM_CMD_IDLE;
			memory_address_lines_out         <= '0;
			special_cycle_out                <= 1'b0;
		end else if (cpu_dram_req_in) begin
			{ras_n_out, cas_n_out, we_n_out} <= sel_cmd;
			memory_address_lines_out         <= sel_addr;
			special_cycle_out                <= sel_special;
		end else begin
			{ras_n_out, cas_n_out, we_n_out} <= SCM_CMD_IDLE;
			special_cycle_out                <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// command pins gathered for the checks below
	logic [2:0] issued_cmd;

	assign issued_cmd = {ras_n_out, cas_n_out, we_n_out};

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	chk_reset_mode_zero: assert property (
		$past(srst_in)
		|-> mode_field == SCM_NORMAL_MODE)
		else $error("mode field not zero after reset");

	chk_reset_cmd_idle: assert property (
		$past(srst_in)
		|-> issued_cmd == SCM_CMD_IDLE && !special_cycle_out)
		else $error("command not idle after reset");

	chk_reset_cas_zero: assert property (
		$past(srst_in)
		|-> !cas_latency_select_out)
		else $error("cas latency bit not zero after reset");

	// ----------------------------------------
	// command translation
	// ----------------------------------------
	chk_normal_access: assert property (
		cpu_dram_req_in && (mode_field == SCM_NORMAL_MODE || mode_field > SCM_REFRESH_CYCLE)
		|=> issued_cmd == ($past(cpu_dram_write_in) ? SCM_CMD_WRITE : SCM_CMD_READ)
		&& !special_cycle_out)
		else $error("normal access not issued");

	chk_normal_address: assert property (
		cpu_dram_req_in && mode_field == SCM_NORMAL_MODE
		|=> memory_address_lines_out == $past(cpu_mem_addr_in))
		else $error("normal access address wrong");

	chk_nop_mode: assert property (
		cpu_dram_req_in && mode_field == SCM_IDLE_COMMAND_MODE
		|=> issued_cmd == SCM_CMD_NOP && special_cycle_out)
		else $error("nop mode gave another command");

	chk_precharge_all: assert property (
		cpu_dram_req_in && mode_field == SCM_PRECHARGE_ALL
		|=> issued_cmd == SCM_CMD_PRECHARGE
		&& memory_address_lines_out[SCM_ALL_BANKS_BIT])
		else $error("precharge-all not issued");

	chk_mode_program: assert property (
		cpu_dram_req_in && mode_field == SCM_MODE_PROGRAM
		|=> issued_cmd == SCM_CMD_LOAD_MODE
		&& memory_address_lines_out == $past(cpu_mem_addr_in))
		else $error("mode register set wrong");

	chk_refresh_mode: assert property (
		cpu_dram_req_in && mode_field == SCM_REFRESH_CYCLE
		|=> issued_cmd == SCM_CMD_REFRESH && special_cycle_out)
		else $error("refresh cycle not issued");

	chk_special_source: assert property (
		special_cycle_out
		|-> $past(cpu_dram_req_in)
		&& $past(mode_field) >= SCM_IDLE_COMMAND_MODE
		&& $past(mode_field) <= SCM_REFRESH_CYCLE)
		else $error("special flag without a special request");

	chk_idle_no_req: assert property (
		!cpu_dram_req_in
		|=> issued_cmd == SCM_CMD_IDLE && !special_cycle_out)
		else $error("command without a request");

	// ----------------------------------------
	// register port
	// ----------------------------------------
	chk_mode_write: assert property (
		reg_wr_in && reg_addr_in == SCM_CTRL_OFFSET
		|=> mode_field == $past(reg_wdata_in[SCM_MODE_MSB:SCM_MODE_LSB]))
		else $error("mode field write lost");

	chk_cas_latency: assert property (
		reg_wr_in && reg_addr_in == SCM_CTRL_OFFSET
		|=> cas_latency_select_out == $past(reg_wdata_in[SCM_CAS_BIT]))
		else $error("cas latency bit write lost");

	chk_read_back: assert property (
		reg_rd_in && reg_addr_in == SCM_CTRL_OFFSET && !reg_wr_in
		|=> reg_rdata_out[SCM_MODE_MSB:SCM_MODE_LSB] == $past(mode_field)
		&& reg_rdata_out[15:9] == 7'h00)
		else $error("read data mismatch");

	chk_read_idle: assert property (
		!(reg_rd_in && reg_addr_in == SCM_CTRL_OFFSET)
		|=> reg_rdata_out == SCM_UNMAPPED_DATA)
		else $error("read data not zero outside a read");

	// ----------------------------------------
	// coverage
	// ----------------------------------------
	cov_nop: cover property (cpu_dram_req_in && mode_field == SCM_IDLE_COMMAND_MODE);
	cov_precharge: cover property (cpu_dram_req_in && mode_field == SCM_PRECHARGE_ALL);
	cov_mrs: cover property (cpu_dram_req_in && mode_field == SCM_MODE_PROGRAM);
	cov_refresh: cover property (cpu_dram_req_in && mode_field == SCM_REFRESH_CYCLE);
	cov_refresh_pair: cover property (cpu_dram_req_in && mode_field == SCM_REFRESH_CYCLE
		##1 cpu_dram_req_in);

endmodule

// ---- dv/scm_sdram_command_mode_tb.sv ----
// testbench: register access and command translation of the sdram command-mode block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", n, e, g); end end

module scm_sdram_command_mode_tb;
	import scm_pkg::*;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic        req = 1'b0;
	logic        wr = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic [15:0] rdata;
	logic [11:0] maddr = 12'h000;
	logic [11:0] lines;
	logic [11:0] mreg;
	logic        ras_n, cas_n, we_n, special, cas_bit;
	logic [2:0]  mode;
	logic [7:0]  rcnt;
	int          error_cnt = 0;
	int          cmp_count = 0;

	scm_sdram_command_mode u_dut (.clk_in(clk_in), .srst_in(srst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .cpu_dram_req_in(req),
		.cpu_dram_write_in(wr), .cpu_mem_addr_in(maddr), .memory_address_lines_out(lines),
		.ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
		.special_command_mode_field_out(mode), .cas_latency_select_out(cas_bit),
		.special_cycle_out(special));
	scm_sdram_model u_mem (.clk_in(clk_in), .srst_in(srst_in), .addr_in(lines),
		.ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .mode_reg_out(mreg),
		.refresh_cnt_out(rcnt));

	initial begin
		forever #12.5 clk_in = ~clk_in;
	end

	// ----------------------------------------
	// bus and request tasks
	// ----------------------------------------
	task reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		d = rdata;
	endtask

	task cpu(input logic w, input logic [11:0] a);
		@(posedge clk_in);
		req <= 1'b1;
		wr <= w;
		maddr <= a;
		@(posedge clk_in);
		req <= 1'b0;
		@(negedge clk_in);
	endtask

	function automatic logic [2:0] exp_cmd(input logic [2:0] m, input logic w);
		case (m)
			3'h1: exp_cmd = SCM_CMD_NOP;
			3'h2: exp_cmd = SCM_CMD_PRECHARGE;
			3'h3: exp_cmd = SCM_CMD_LOAD_MODE;
			3'h4: exp_cmd = SCM_CMD_REFRESH;
			default: exp_cmd = w ? SCM_CMD_WRITE : SCM_CMD_READ;
		endcase
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		logic [15:0] d;
		reg_rd(8'h54, d);
		`CHK("reset value", 16'h0000, d)
		`CHK("idle cmd", 3'h7, {ras_n, cas_n, we_n})
		reg_wr(8'h54, 16'hffff);
		reg_rd(8'h54, d);
		`CHK("writable bits", 16'h01f0, d)
		`CHK("cas bit", 1'b1, cas_bit)
		reg_wr(8'h56, 16'h0000);
		reg_rd(8'h54, d);
		`CHK("unmapped write", 16'h01f0, d)
		reg_rd(8'h56, d);
		`CHK("unmapped read", 16'h0000, d)
		reg_wr(8'h54, 16'h0000);
		$display("test regs done");
	endtask

	task t_modes;
		logic [2:0] m;
		for (int i = 0; i < 8; i++) begin
			m = 3'(i + 1);
			reg_wr(8'h54, {7'h00, m, 6'h00}); // nop code comes first
			cpu(i[0], 12'h02a);
			`CHK("mode", m, mode)
			`CHK("cmd", exp_cmd(m, i[0]), {ras_n, cas_n, we_n})
			`CHK("lines", (m == 3'h2) ? 12'h42a : 12'h02a, lines)
			`CHK("special", (m >= 3'h1 && m <= 3'h4), special)
		end
		`CHK("mode reg", 12'h02a, mreg)
		`CHK("cas bit clear", 1'b0, cas_bit)
		`CHK("ma4", 1'b0, mreg[4])
		$display("test modes done");
	endtask

	task t_b2b;
		logic [7:0] n;
		reg_wr(8'h54, 16'h0100);
		n = rcnt;
		@(posedge clk_in);
		req <= 1'b1;
		@(posedge clk_in);
		@(posedge clk_in);
		req <= 1'b0;
		@(negedge clk_in);
		`CHK("second refresh", 3'h1, {ras_n, cas_n, we_n})
		@(negedge clk_in);
		`CHK("after refresh", 3'h7, {ras_n, cas_n, we_n})
		`CHK("refresh count", n + 8'h02, rcnt)
		reg_wr(8'h54, 16'h0000);
		$display("test back-to-back done");
	endtask

	task t_reset;
		logic [15:0] d;
		reg_wr(8'h54, 16'h0050);
		cpu(1'b0, 12'h3ff);
		`CHK("lines before reset", 12'h3ff, lines)
		`CHK("cas before reset", 1'b1, cas_bit)
		@(posedge clk_in);
		srst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		@(negedge clk_in);
		`CHK("mode after reset", 3'h0, mode)
		`CHK("cas after reset", 1'b0, cas_bit)
		`CHK("cmd after reset", 3'h7, {ras_n, cas_n, we_n})
		`CHK("lines after reset", 12'h000, lines)
		`CHK("special after reset", 1'b0, special)
		reg_rd(8'h54, d);
		`CHK("reg after reset", 16'h0000, d)
		$display("test mid-run reset done");
	endtask

	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		t_regs();
		t_modes();
		t_b2b();
		t_reset();
		final_report();
	end

	initial begin
		repeat (2000) @(posedge clk_in);
		error_cnt++;
		final_report();
	end
endmodule

// ---- dv/scm_sdram_model.sv ----
// partner model: sdram devices that record mode-set values and refresh cycles
`timescale 1ns/1ps

module scm_sdram_model
	import scm_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	// memory interface
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              ras_n_in,
	input  wire logic              cas_n_in,
	input  wire logic              we_n_in,
	// observed state
	output logic      [ADDR_W-1:0] mode_reg_out,
	output logic      [7:0]        refresh_cnt_out
);
	// ----------------------------------------
	// command decode
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mode_reg_out    <= '0;
			refresh_cnt_out <= 8'h00;
		end else if ({ras_n_in, cas_n_in, we_n_in} == SCM_CMD_LOAD_MODE) begin
			mode_reg_out <= addr_in;
		end else if ({ras_n_in, cas_n_in, we_n_in} == SCM_CMD_REFRESH) begin
			refresh_cnt_out <= refresh_cnt_out + 8'h01;
		end
	end
endmodule
